// ==== ptu_checker.sv ====
// port assertions of the pulse timer unit
`timescale 1ns/1ns
`include "ptu_defines.svh"
module ptu_checker (
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic [1:0]  O_CC_PIN_A,
  input wire logic [1:0]  O_CC_PIN_A_OE
);
  logic       run_q;
  logic [3:0] pfa_q;
  logic       rd_mode;
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  // shadow of channel one run bit and pin a code
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      run_q <= 1'b0;
      pfa_q <= 4'h0;
    end else if (O_PREADY && I_PWRITE && !O_PSLVERR) begin
      if (I_PADDR == `PTU_OFF_RUN) run_q <= I_PWDATA[0];
      if (I_PADDR == `PTU_OFF_PINF) pfa_q <= I_PWDATA[3:0];
    end
  end
  // read of either mode register completing
  assign rd_mode = O_PREADY && !I_PWRITE && (I_PADDR == `PTU_OFF_MODE
                   || I_PADDR == `PTU_OFF_MODE + `PTU_CH_STRIDE);
  sequence s_first;
    I_PSEL && I_PENABLE && !$past(I_PENABLE);
  endsequence
  property p_one_wait;
    s_first |=> O_PREADY;
  endproperty
  property p_pulse;
    O_PREADY |=> !O_PREADY;
  endproperty
  property p_in_access;
    O_PREADY |-> I_PSEL && I_PENABLE;
  endproperty
  property p_idle_data;
    !O_PREADY |-> O_PRDATA == 32'h0;
  endproperty
  property p_err_ready;
    O_PSLVERR |-> O_PREADY;
  endproperty
  property p_unmapped;
    O_PREADY && I_PADDR > `PTU_OFF_RUN |-> O_PSLVERR && O_PRDATA == 32'h0;
  endproperty
  property p_mode_rd;
    rd_mode |-> O_PRDATA[31:2] == 30'h0000_0030;
  endproperty
  property p_pinf_rd;
    O_PREADY && !I_PWRITE && I_PADDR == `PTU_OFF_PINF
      |-> O_PRDATA[31:8] == 24'h00_0000;
  endproperty
  property p_stop_lvl;
    !run_q && $stable(run_q) && $stable(pfa_q) && !pfa_q[3]
      && pfa_q[1:0] != 2'h0 |-> O_CC_PIN_A[0] == pfa_q[2] && O_CC_PIN_A_OE[0];
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready late");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_in_access: assert property (p_in_access) else $error("stray ready");
  a_idle_data: assert property (p_idle_data) else $error("stray read data");
  a_err_ready: assert property (p_err_ready) else $error("stray error");
  a_unmapped: assert property (p_unmapped) else $error("unmapped answered");
  a_mode_rd: assert property (p_mode_rd) else $error("mode bits");
  a_pinf_rd: assert property (p_pinf_rd) else $error("pin code bits");
  a_stop_lvl: assert property (p_stop_lvl) else $error("stop level");
endmodule : ptu_checker

bind ptu_top ptu_checker i_chk (.I_CORE_CLK, .I_RST, .I_PSEL, .I_PENABLE,
  .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR,
  .O_CC_PIN_A, .O_CC_PIN_A_OE);

// ==== ptu_defines.svh ====
// offsets, field positions, reset values and counts of the pulse timer unit
`ifndef PTU_DEFINES_SVH
`define PTU_DEFINES_SVH

`define PTU_OFF_CLK      8'h00
`define PTU_OFF_MODE     8'h04
`define PTU_OFF_PINF     8'h08
`define PTU_OFF_CNT      8'h0C
`define PTU_OFF_GRA      8'h10
`define PTU_OFF_GRB      8'h14
`define PTU_CH_STRIDE    8'h18
`define PTU_OFF_RUN      8'h30

`define PTU_RST_CLK      8'h00
`define PTU_RST_MODE     2'h0
`define PTU_MODE_FIXED   6'h30
`define PTU_RST_PINF     8'h00
`define PTU_RST_CNT      16'h0000
`define PTU_RST_GR       16'hFFFF
`define PTU_CNT_MAX      16'hFFFF

`define PTU_PSC_MSB      2
`define PTU_EDGE_MSB     4
`define PTU_EDGE_LSB     3
`define PTU_PINB_MSB     7
`define PTU_PINB_LSB     4
`define PTU_PINA_MSB     3
`define PTU_PINA_LSB     0

`define PTU_DIV_W        10
`define PTU_DIV_STAGES   5

`endif

// ==== ptu_edge.sv ====
// two-flop synchroniser with rise and fall pulses for pin inputs
`timescale 1ns/1ns
module ptu_edge #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edge pulses from the synchronised level
  always_comb begin
    o_rise = sync_q & ~prev_q;
    o_fall = ~sync_q & prev_q;
  end

endmodule : ptu_edge

// ==== ptu_partner.sv ====
// model of the external count sources
`timescale 1ns/1ns
module ptu_partner (
  input  wire logic i_clk,
  input  wire logic i_go,
  output logic      o_ext_a,
  output logic      o_ext_b,
  output logic      o_ext_c,
  output logic      o_done
);
  // bursts of 3, 5 and 7 pulses, lines low between bursts
  initial begin
    {o_ext_c, o_ext_b, o_ext_a, o_done} = 4'h0;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        o_done <= 1'b0;
        for (int p = 0; p < 7; p++) begin
          {o_ext_c, o_ext_b, o_ext_a} <= {1'b1, p < 5, p < 3};
          repeat (4) @(posedge i_clk);
          {o_ext_c, o_ext_b, o_ext_a} <= 3'h0;
          repeat (4) @(posedge i_clk);
        end
        o_done <= 1'b1;
      end
    end
  end
endmodule : ptu_partner

// ==== ptu_pkg.sv ====
// types of the pulse timer unit
package ptu_pkg;

  typedef enum logic [1:0] {
    PTU_MODE_NORMAL = 2'h0,
    PTU_MODE_RSVD   = 2'h1,
    PTU_MODE_PWM1   = 2'h2,
    PTU_MODE_PWM2   = 2'h3
  } ptu_mode_t;

  // prescaler edge pulses: /4, /16, /64, /256, /1024
  typedef struct packed {
    logic [4:0] rise;
    logic [4:0] fall;
  } ptu_tick_t;

  // one compare/capture pin driver
  typedef struct packed {
    logic out;
    logic oe;
  } ptu_pin_t;

endpackage : ptu_pkg

// ==== ptu_presc.sv ====
// free running prescaler giving edge pulses of the divided clocks
`timescale 1ns/1ns
`include "ptu_defines.svh"
module ptu_presc
  import ptu_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  output ptu_tick_t o_tick
);

  logic [`PTU_DIV_W-1:0] div_q;
  logic [`PTU_DIV_W-1:0] div_d;

  // divider chain next value
  always_comb begin
    div_d = div_q + 10'h001;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // stage k divides by 4**(k+1); rise at half period, fall at wrap
  always_comb begin
    logic [`PTU_DIV_W-1:0] mask;
    logic [`PTU_DIV_W-1:0] half;
    mask   = '0;
    half   = '0;
    o_tick = '0;
    for (int k = 0; k < `PTU_DIV_STAGES; k++) begin
      mask = `PTU_DIV_W'((1 << (2 * k + 2)) - 1);
      half = `PTU_DIV_W'((1 << (2 * k + 1)) - 1);
      o_tick.rise[k] = (div_q & mask) == half;
      o_tick.fall[k] = (div_q & mask) == mask;
    end
  end

endmodule : ptu_presc

// ==== ptu_top.sv ====
// two channel pulse timer unit with APB registers and compare/capture pins
//
// Functional notes
// - ch1 codes 000/001/010/011/110 count clock /1,/4,/16,/64,/256.
// - ch1 code 100 counts external input A, 101 external input B.
// - ch1 code 111 counts once per ch2 counter overflow.
// - ch2 codes 000..011 count /1,/4,/16,/64; code 111 counts /1024.
// - ch2 codes 100,101,110 count external inputs A, B, C.
// - mode 00 normal, 10 first PWM, 11 second PWM; 01 reserved.
// - mode bits 7,6 read one, bits 5,4 read zero, unwritable.
// - initial pin level is driven while the channel is stopped.
// - second PWM mode applies the pin level when counter wraps to zero.
// - pin function bits 7:4 for register B, 3:0 for A; reset zero.
// - code 0xyy compare: yy=00 off, 01/10/11 drive 0/1/toggle; x initial.
// - ch1 code 1000 rise, 1001 fall, 101x both capture; 11xx prohibited.
// - edge select ignored at undivided clock; rising counted there.
`timescale 1ns/1ns
`include "ptu_defines.svh"
module ptu_top
  import ptu_pkg::*;
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_EXT_COUNT_IN_A,
  input  wire logic        I_EXT_COUNT_IN_B,
  input  wire logic        I_EXT_COUNT_IN_C,
  input  wire logic [1:0]  I_CC_PIN_A,
  input  wire logic [1:0]  I_CC_PIN_B,
  output logic      [1:0]  O_CC_PIN_A,
  output logic      [1:0]  O_CC_PIN_A_OE,
  output logic      [1:0]  O_CC_PIN_B,
  output logic      [1:0]  O_CC_PIN_B_OE
);

  ptu_tick_t   tick;
  logic [2:0]  ext_rise;
  logic [2:0]  ext_fall;
  logic [1:0]  cca_rise;
  logic [1:0]  cca_fall;
  logic [1:0]  ccb_rise;
  logic [1:0]  ccb_fall;

  logic [7:0]  clk_ctl_q   [2];
  logic [7:0]  clk_ctl_d   [2];
  logic [1:0]  mode_q      [2];
  logic [1:0]  mode_d      [2];
  logic [7:0]  pin_func_q  [2];
  logic [7:0]  pin_func_d  [2];
  logic [15:0] counter_q   [2];
  logic [15:0] counter_d   [2];
  logic [15:0] gen_a_q     [2];
  logic [15:0] gen_a_d     [2];
  logic [15:0] gen_b_q     [2];
  logic [15:0] gen_b_d     [2];
  ptu_pin_t    pin_a_q     [2];
  ptu_pin_t    pin_a_d     [2];
  ptu_pin_t    pin_b_q     [2];
  ptu_pin_t    pin_b_d     [2];
  logic [1:0]  run_q;
  logic [1:0]  run_d;
  logic [1:0]  count_en;
  logic [1:0]  wrap;

  logic        wr_stb;
  logic        pready_d;
  logic        pready_q;
  logic [31:0] prdata_d;
  logic [31:0] prdata_q;
  logic        pslverr_d;
  logic        pslverr_q;
  logic        hit;

  // pin synchronisers and the divided clock edges
  ptu_edge #(.W(3)) u_ext_edge (
    .i_clk  (I_CORE_CLK),
    .i_rst  (I_RST),
    .i_pin  ({I_EXT_COUNT_IN_C, I_EXT_COUNT_IN_B, I_EXT_COUNT_IN_A}),
    .o_rise (ext_rise),
    .o_fall (ext_fall)
  );

  ptu_edge #(.W(4)) u_cc_edge (
    .i_clk  (I_CORE_CLK),
    .i_rst  (I_RST),
    .i_pin  ({I_CC_PIN_B, I_CC_PIN_A}),
    .o_rise ({ccb_rise, cca_rise}),
    .o_fall ({ccb_fall, cca_fall})
  );

  ptu_presc u_presc (
    .i_clk  (I_CORE_CLK),
    .i_rst  (I_RST),
    .o_tick (tick)
  );

  // pick the counted edges: 00 rising, 01 falling, 1x both
  function automatic logic pick_edge(input logic r, input logic f,
                                     input logic [1:0] e);
    pick_edge = e[1] ? (r | f) : (e[0] ? f : r);
  endfunction : pick_edge

  // pin level taken at a compare match
  function automatic logic match_level(input logic [3:0] code,
                                       input logic cur);
    case (code[1:0])
      2'h1:    match_level = 1'b0;
      2'h2:    match_level = 1'b1;
      2'h3:    match_level = ~cur;
      default: match_level = cur;
    endcase
  endfunction : match_level

  // count enables of both channels
  always_comb begin
    logic [1:0] e1;
    logic [1:0] e2;
    e1 = clk_ctl_q[0][`PTU_EDGE_MSB:`PTU_EDGE_LSB];
    e2 = clk_ctl_q[1][`PTU_EDGE_MSB:`PTU_EDGE_LSB];
    case (clk_ctl_q[1][`PTU_PSC_MSB:0])
      3'h0:    count_en[1] = 1'b1;
      3'h1:    count_en[1] = pick_edge(tick.rise[0], tick.fall[0], e2);
      3'h2:    count_en[1] = pick_edge(tick.rise[1], tick.fall[1], e2);
      3'h3:    count_en[1] = pick_edge(tick.rise[2], tick.fall[2], e2);
      3'h4:    count_en[1] = pick_edge(ext_rise[0], ext_fall[0], e2);
      3'h5:    count_en[1] = pick_edge(ext_rise[1], ext_fall[1], e2);
      3'h6:    count_en[1] = pick_edge(ext_rise[2], ext_fall[2], e2);
      default: count_en[1] = pick_edge(tick.rise[4], tick.fall[4], e2);
    endcase
    wrap[1] = run_q[1] & count_en[1] & (counter_q[1] == `PTU_CNT_MAX);
    case (clk_ctl_q[0][`PTU_PSC_MSB:0])
      3'h0:    count_en[0] = 1'b1;
      3'h1:    count_en[0] = pick_edge(tick.rise[0], tick.fall[0], e1);
      3'h2:    count_en[0] = pick_edge(tick.rise[1], tick.fall[1], e1);
      3'h3:    count_en[0] = pick_edge(tick.rise[2], tick.fall[2], e1);
      3'h4:    count_en[0] = pick_edge(ext_rise[0], ext_fall[0], e1);
      3'h5:    count_en[0] = pick_edge(ext_rise[1], ext_fall[1], e1);
      3'h6:    count_en[0] = pick_edge(tick.rise[3], tick.fall[3], e1);
      default: count_en[0] = wrap[1];
    endcase
    wrap[0] = run_q[0] & count_en[0] & (counter_q[0] == `PTU_CNT_MAX);
  end

  // APB: access takes effect in its second cycle, when pready is high
  always_comb begin
    wr_stb   = I_PSEL & I_PENABLE & pready_q & I_PWRITE;
    pready_d = I_PSEL & I_PENABLE & ~pready_q;
    hit      = 1'b1;
    prdata_d = 32'h0000_0000;
    case (I_PADDR)
      `PTU_OFF_CLK:  prdata_d = {24'h00_0000, clk_ctl_q[0]};
      `PTU_OFF_MODE: prdata_d = {24'h00_0000, `PTU_MODE_FIXED, mode_q[0]};
      `PTU_OFF_PINF: prdata_d = {24'h00_0000, pin_func_q[0]};
      `PTU_OFF_CNT:  prdata_d = {16'h0000, counter_q[0]};
      `PTU_OFF_GRA:  prdata_d = {16'h0000, gen_a_q[0]};
      `PTU_OFF_GRB:  prdata_d = {16'h0000, gen_b_q[0]};
      `PTU_OFF_CLK + `PTU_CH_STRIDE:
        prdata_d = {24'h00_0000, clk_ctl_q[1]};
      `PTU_OFF_MODE + `PTU_CH_STRIDE:
        prdata_d = {24'h00_0000, `PTU_MODE_FIXED, mode_q[1]};
      `PTU_OFF_PINF + `PTU_CH_STRIDE:
        prdata_d = {24'h00_0000, pin_func_q[1]};
      `PTU_OFF_CNT + `PTU_CH_STRIDE:
        prdata_d = {16'h0000, counter_q[1]};
      `PTU_OFF_GRA + `PTU_CH_STRIDE:
        prdata_d = {16'h0000, gen_a_q[1]};
      `PTU_OFF_GRB + `PTU_CH_STRIDE:
        prdata_d = {16'h0000, gen_b_q[1]};
      `PTU_OFF_RUN:  prdata_d = {30'h0000_0000, run_q};
      default:       hit = 1'b0;
    endcase
    if (!pready_d || I_PWRITE) begin
      prdata_d = 32'h0000_0000;
    end
    pslverr_d = pready_d & ~hit;
    run_d     = run_q;
    if (wr_stb && I_PADDR == `PTU_OFF_RUN) begin
      run_d = I_PWDATA[1:0];
    end
  end

  // per channel registers, counter, compare and capture
  for (genvar c = 0; c < 2; c++) begin : g_ch
    localparam logic [7:0] BASE = (c == 0) ? 8'h00 : `PTU_CH_STRIDE;
    always_comb begin
      logic [3:0] code_a;
      logic [3:0] code_b;
      logic       cap_a;
      logic       cap_b;
      logic       hit_a;
      logic       hit_b;
      logic       pwm1;
      logic       pwm2;
      code_a = pin_func_q[c][`PTU_PINA_MSB:`PTU_PINA_LSB];
      code_b = pin_func_q[c][`PTU_PINB_MSB:`PTU_PINB_LSB];
      pwm1   = mode_q[c] == PTU_MODE_PWM1;
      pwm2   = mode_q[c] == PTU_MODE_PWM2;
      hit_a  = run_q[c] & count_en[c] & ~code_a[3] &
               (counter_q[c] == gen_a_q[c]);
      hit_b  = run_q[c] & count_en[c] & ~code_b[3] &
               (counter_q[c] == gen_b_q[c]);
      // capture edge select; ch1 11xx captures nothing
      cap_a  = code_a[3] & ~(c == 0 && code_a[2]) &
               pick_edge(cca_rise[c], cca_fall[c], code_a[1:0]);
      cap_b  = code_b[3] & ~(c == 0 && code_b[2]) &
               pick_edge(ccb_rise[c], ccb_fall[c], code_b[1:0]);
      clk_ctl_d[c]  = clk_ctl_q[c];
      mode_d[c]     = mode_q[c];
      pin_func_d[c] = pin_func_q[c];
      counter_d[c]  = counter_q[c];
      gen_a_d[c]    = cap_a ? counter_q[c] : gen_a_q[c];
      gen_b_d[c]    = cap_b ? counter_q[c] : gen_b_q[c];
      if (run_q[c] && count_en[c]) begin
        counter_d[c] = counter_q[c] + 16'h0001;
      end
      if (wr_stb) begin
        case (I_PADDR)
          BASE + `PTU_OFF_CLK:  clk_ctl_d[c]  = {3'h0, I_PWDATA[4:0]};
          BASE + `PTU_OFF_MODE: mode_d[c]     = I_PWDATA[1:0];
          BASE + `PTU_OFF_PINF: pin_func_d[c] = I_PWDATA[7:0];
          BASE + `PTU_OFF_CNT:  counter_d[c]  = I_PWDATA[15:0];
          BASE + `PTU_OFF_GRA:  gen_a_d[c]    = I_PWDATA[15:0];
          BASE + `PTU_OFF_GRB:  gen_b_d[c]    = I_PWDATA[15:0];
          default: ;
        endcase
      end
      // pin drivers: enabled for compare codes with yy other than 00; pin b disabled in first PWM mode
      pin_a_d[c].oe = ~code_a[3] & (code_a[1:0] != 2'h0);
      pin_b_d[c].oe = ~code_b[3] & (code_b[1:0] != 2'h0) & ~pwm1;
      pin_a_d[c].out = pin_a_q[c].out;
      pin_b_d[c].out = pin_b_q[c].out;
      if (!run_q[c]) begin
        pin_a_d[c].out = code_a[2];
        pin_b_d[c].out = code_b[2];
      end else if (pwm2 && wrap[c]) begin
        pin_a_d[c].out = code_a[2];
        pin_b_d[c].out = code_b[2];
      end else begin
        if (hit_a) begin
          pin_a_d[c].out = match_level(code_a, pin_a_q[c].out);
        end
        if (pwm1 && hit_b) begin
          pin_a_d[c].out = match_level(code_b, pin_a_q[c].out);
        end
        if (!pwm1 && hit_b) begin
          pin_b_d[c].out = match_level(code_b, pin_b_q[c].out);
        end
      end
    end

    always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
        clk_ctl_q[c]  <= `PTU_RST_CLK;
        mode_q[c]     <= `PTU_RST_MODE;
        pin_func_q[c] <= `PTU_RST_PINF;
        counter_q[c]  <= `PTU_RST_CNT;
        gen_a_q[c]    <= `PTU_RST_GR;
        gen_b_q[c]    <= `PTU_RST_GR;
        pin_a_q[c]    <= '0;
        pin_b_q[c]    <= '0;
      end else begin
        clk_ctl_q[c]  <= clk_ctl_d[c];
        mode_q[c]     <= mode_d[c];
        pin_func_q[c] <= pin_func_d[c];
        counter_q[c]  <= counter_d[c];
        gen_a_q[c]    <= gen_a_d[c];
        gen_b_q[c]    <= gen_b_d[c];
        pin_a_q[c]    <= pin_a_d[c];
        pin_b_q[c]    <= pin_b_d[c];
      end
    end
  end

  // bus answer and run bits
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      run_q     <= 2'h0;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
      run_q     <= run_d;
    end
  end

  // outputs straight from flops
  always_comb begin
    O_PREADY  = pready_q;
    O_PRDATA  = prdata_q;
    O_PSLVERR = pslverr_q;
    for (int c = 0; c < 2; c++) begin
      O_CC_PIN_A[c]    = pin_a_q[c].out;
      O_CC_PIN_A_OE[c] = pin_a_q[c].oe;
      O_CC_PIN_B[c]    = pin_b_q[c].out;
      O_CC_PIN_B_OE[c] = pin_b_q[c].oe;
    end
  end

endmodule : ptu_top

// ==== two_channel_timer_clock_mode_io_bench.sv ====
// self-checking bench of the pulse timer unit
`timescale 1ns/1ns
`include "ptu_defines.svh"
module two_channel_timer_clock_mode_io_bench;
  typedef struct packed {
    logic        err;
    logic [31:0] lo;
    logic [31:0] hi;
  } ptu_exp_t;
  typedef struct packed {
    logic [1:0]  md;
    logic [7:0]  pf;
    logic [15:0] cnt, gra, grb;
    logic [3:0]  stp, run;
  } ptu_row_t;
  localparam ptu_row_t rows [5] = '{
    '{2'h0, 8'h00, 16'h0000, 16'h0005, 16'h0008, 4'h0, 4'h0},
    '{2'h0, 8'h52, 16'h0000, 16'h0005, 16'h0008, 4'h7, 4'hD},
    '{2'h0, 8'h73, 16'h0000, 16'h0005, 16'h0008, 4'h7, 4'hD},
    '{2'h3, 8'h02, 16'hFFF0, 16'hFFF4, 16'h0008, 4'h4, 4'h4},
    '{2'h2, 8'h12, 16'h0000, 16'h0005, 16'h000A, 4'h4, 4'h4}};
  localparam logic [7:0] pctl [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06,
    8'h09, 8'h11, 8'h18, 8'h00, 8'h01, 8'h02, 8'h03, 8'h07};
  localparam int pd [13] = '{1, 4, 16, 64, 256, 4, 2, 1, 1, 4, 16, 64, 1024};
  localparam int pw [13] = '{8, 32, 128, 512, 2048, 32, 32, 8, 8, 32, 128,
    512, 8192};
  localparam logic [7:0] capc [5] = '{8'h08, 8'h09, 8'h09, 8'h0A, 8'h0C};
  localparam logic [4:0] capm = 5'h0B;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        ext_a, ext_b, ext_c, go, done;
  logic [7:0]  paddr, b;
  logic [31:0] pwdata, prdata, v;
  logic [15:0] g;
  logic [1:0]  cc_a, cc_b, pa, pa_oe, pb, pb_oe;
  ptu_exp_t    expq [$];
  int          errors, tests_run, n, k;

  ptu_top i_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_EXT_COUNT_IN_A(ext_a), .I_EXT_COUNT_IN_B(ext_b),
    .I_EXT_COUNT_IN_C(ext_c), .I_CC_PIN_A(cc_a), .I_CC_PIN_B(cc_b),
    .O_CC_PIN_A(pa), .O_CC_PIN_A_OE(pa_oe), .O_CC_PIN_B(pb),
    .O_CC_PIN_B_OE(pb_oe));
  ptu_partner i_far (.i_clk(clk), .i_go(go), .o_ext_a(ext_a),
    .o_ext_b(ext_b), .o_ext_c(ext_c), .o_done(done));

  // 20 MHz core clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic results();
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic stuck();
    errors++;
    results();
  endtask : stuck
  task automatic fail(input logic [31:0] got, input logic [31:0] want);
    errors++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
  endtask : fail
  task automatic cmp_rd(input ptu_exp_t e, input logic [31:0] d,
                        input logic s);
    tests_run++;
    if (!(s === e.err && (d >= e.lo) === 1'b1 && (d <= e.hi) === 1'b1))
      fail(d, e.lo);
  endtask : cmp_rd
  task automatic cmp_pin(input int c, input logic [3:0] w);
    tests_run++;
    if ({pa[c], pa_oe[c], pb[c], pb_oe[c]} !== w)
      fail({28'h0, pa[c], pa_oe[c], pb[c], pb_oe[c]}, {28'h0, w});
  endtask : cmp_pin
  // one apb transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    c = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++c < 16);
    if (pready !== 1'b1) stuck();
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdr(input logic [7:0] a, input logic [31:0] lo,
                     input logic [31:0] hi, input logic s);
    expq.push_back('{s, lo, hi});
    apb(1'b0, a, 32'h0);
  endtask : rdr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rdr(a, x, x, 1'b0);
  endtask : rd

  // read results against the oldest note
  always @(posedge clk) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      if (expq.size() == 0) fail(prdata, 32'h0);
      else cmp_rd(expq.pop_front(), prdata, pslverr);
    end
  end

  // main sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, go, cc_a, cc_b} = '0;
    errors = 0;
    tests_run = 0;
    v = $urandom(32'h56ac5d9c);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int c = 0; c < 2; c++) begin
      b = c[0] ? `PTU_CH_STRIDE : 8'h00;
      rd(b + `PTU_OFF_MODE, 32'h0000_00C0);
      rd(b + `PTU_OFF_PINF, 32'h0);
    end
    wr(`PTU_OFF_MODE, 32'h0000_00F3);
    rd(`PTU_OFF_MODE, 32'h0000_00C3);
    wr(`PTU_OFF_MODE + `PTU_CH_STRIDE, 32'h0000_0032);
    rd(`PTU_OFF_MODE + `PTU_CH_STRIDE, 32'h0000_00C2);
    rdr(8'h40, 32'h0, 32'h0, 1'b1);
    v = $urandom();
    wr(`PTU_OFF_PINF + `PTU_CH_STRIDE, v);
    rd(`PTU_OFF_PINF + `PTU_CH_STRIDE, {24'h0, v[7:0]});
    for (int i = 0; i < 13; i++) begin
      b = (i < 8) ? 8'h00 : `PTU_CH_STRIDE;
      wr(b + `PTU_OFF_CLK, pctl[i]);
      wr(b + `PTU_OFF_CNT, 32'h0);
      wr(`PTU_OFF_RUN, (i < 8) ? 32'h1 : 32'h2);
      repeat (pw[i]) @(posedge clk);
      wr(`PTU_OFF_RUN, 32'h0);
      rdr(b + `PTU_OFF_CNT, pw[i] / pd[i], (pw[i] + 16) / pd[i] + 1, 1'b0);
    end
    for (int i = 0; i < 5; i++) begin
      b = (i < 2) ? 8'h00 : `PTU_CH_STRIDE;
      k = (i < 2) ? i : i - 2;
      wr(b + `PTU_OFF_CLK, 32'h4 + k);
      wr(b + `PTU_OFF_CNT, 32'h0);
      wr(`PTU_OFF_RUN, (i < 2) ? 32'h1 : 32'h2);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      do @(posedge clk); while (done !== 1'b1 && ++n < 200);
      if (done !== 1'b1) stuck();
      repeat (8) @(posedge clk);
      wr(`PTU_OFF_RUN, 32'h0);
      rd(b + `PTU_OFF_CNT, 3 + 2 * k);
    end
    wr(`PTU_CH_STRIDE + `PTU_OFF_CLK, 32'h0);
    wr(`PTU_CH_STRIDE + `PTU_OFF_CNT, 32'h0000_FFF0);
    wr(`PTU_OFF_CLK, 32'h7);
    wr(`PTU_OFF_CNT, 32'h0);
    wr(`PTU_OFF_RUN, 32'h3);
    repeat (40) @(posedge clk);
    wr(`PTU_OFF_RUN, 32'h0);
    rd(`PTU_OFF_CNT, 32'h1);
    wr(`PTU_OFF_CLK, 32'h0);
    foreach (rows[i]) begin
      wr(`PTU_OFF_MODE, rows[i].md);
      wr(`PTU_OFF_PINF, rows[i].pf);
      wr(`PTU_OFF_CNT, rows[i].cnt);
      wr(`PTU_OFF_GRA, rows[i].gra);
      wr(`PTU_OFF_GRB, rows[i].grb);
      cmp_pin(0, rows[i].stp);
      wr(`PTU_OFF_RUN, 32'h1);
      repeat (30) @(posedge clk);
      cmp_pin(0, rows[i].run);
      wr(`PTU_OFF_RUN, 32'h0);
    end
    wr(`PTU_OFF_MODE, 32'h0);
    wr(`PTU_OFF_GRA, 32'h0000_1111);
    g = 16'h1111;
    for (int i = 0; i < 5; i++) begin
      v = $urandom();
      wr(`PTU_OFF_CNT, v[15:0]);
      wr(`PTU_OFF_PINF, capc[i]);
      cc_a[0] <= ~i[0];
      repeat (8) @(posedge clk);
      if (capm[i]) g = v[15:0];
      rd(`PTU_OFF_GRA, g);
    end
    // channel two compare pins, then capture on its pin b
    b = `PTU_CH_STRIDE;
    wr(b + `PTU_OFF_MODE, 32'h0);
    wr(b + `PTU_OFF_PINF, 32'h0000_0065);
    wr(b + `PTU_OFF_CNT, 32'h0);
    wr(b + `PTU_OFF_GRA, 32'h0000_0005);
    wr(b + `PTU_OFF_GRB, 32'h0000_0008);
    cmp_pin(1, 4'hF);
    wr(`PTU_OFF_RUN, 32'h2);
    repeat (30) @(posedge clk);
    cmp_pin(1, 4'h7);
    wr(`PTU_OFF_RUN, 32'h0);
    v = $urandom();
    wr(b + `PTU_OFF_CNT, {16'h0000, v[15:0]});
    wr(b + `PTU_OFF_PINF, 32'h0000_00C0);
    cc_b[1] <= 1'b1;
    repeat (8) @(posedge clk);
    rd(b + `PTU_OFF_GRB, {16'h0000, v[15:0]});
    // second reset with both channels stopped clears the pin functions
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    cmp_pin(0, 4'h0);
    cmp_pin(1, 4'h0);
    rd(`PTU_OFF_PINF, 32'h0);
    rd(b + `PTU_OFF_PINF, 32'h0);
    results();
  end
endmodule : two_channel_timer_clock_mode_io_bench
